// ===== src/status_pd_core.v
// Status register and deep power-down controller for the serial memory
`timescale 1ns/1ps
`include "status_pd_defines.vh"
module status_pd_core #(
   parameter ENTRY_CYCLES = `ENTRY_CYCLES,
   parameter RESUME_CYCLES = `RESUME_CYCLES,
   parameter [3:0] DENSITY_CODE = 4'h5
) (
   // Clock and control
   input wire clk_sys,
   input wire reset,
   input wire clk_en,
   // Serial pins
   input wire sck_pin,
   input wire cs_n_pin,
   input wire si_pin,
   output wire so_out,
   output wire so_oe,
   // Array engine events
   input wire op_busy,
   input wire op_done,
   input wire op_is_erase_or_program,
   input wire op_aborted,
   input wire op_failed,
   input wire compare_done,
   input wire compare_mismatch,
   // Array state flags
   input wire lockdown_enabled,
   input wire buf1_suspend,
   input wire buf2_suspend,
   input wire erase_suspend,
   input wire protect_enabled,
   input wire page_size_binary,
   // Buffer modify requests from the command decoder
   input wire buf1_write_req,
   input wire buf2_write_req,
   output wire buf1_write_allow,
   output wire buf2_write_allow,
   // Observed state
   output wire [7:0] status_byte_two,
   output wire [7:0] status_byte_one,
   output reg power_down_q,
   output wire standby,
   output wire command_enable
);
   // Power states, one-hot
   localparam ST_STANDBY = 4'h1;
   localparam ST_ENTERING = 4'h2;
   localparam ST_DOWN = 4'h4;
   localparam ST_RESUMING = 4'h8;

   reg [3:0] state_q;
   reg [3:0] state_d;
   reg [31:0] timer_q;
   reg [31:0] timer_d;
   reg erase_program_error_q;
   reg compare_flag_q;
   reg pending_q;
   reg [7:0] pending_op_q;
   reg status_stream_q;
   wire [7:0] rx_opcode;
   wire rx_opcode_valid;
   wire rx_frame_end;
   wire rx_aligned;
   wire rx_selected;
   wire rx_so;
   wire rx_so_oe;
   wire ready_flag;

   assign ready_flag = ~op_busy;

   ////////////////////////////////////////////////////////////////////////
   // Status byte two assembly
   assign status_byte_two[`SB2_READY_BIT] = ready_flag;
   assign status_byte_two[`SB2_RSVD6_BIT] = 1'b0;
   assign status_byte_two[`SB2_ERROR_BIT] = erase_program_error_q;
   assign status_byte_two[`SB2_RSVD4_BIT] = 1'b0;
   assign status_byte_two[`SB2_LOCKDOWN_BIT] = lockdown_enabled;
   assign status_byte_two[`SB2_PS2_BIT] = buf2_suspend;
   assign status_byte_two[`SB2_PS1_BIT] = buf1_suspend;
   assign status_byte_two[`SB2_ERASE_SUSP_BIT] = erase_suspend;

   // Status byte one; density code is an identifier only, value arbitrary
   assign status_byte_one[`SB1_READY_BIT] = ready_flag;
   assign status_byte_one[`SB1_COMPARE_BIT] = compare_flag_q;
   assign status_byte_one[`SB1_DENSITY_LSB+3:`SB1_DENSITY_LSB] = DENSITY_CODE;
   assign status_byte_one[`SB1_PROTECT_BIT] = protect_enabled;
   assign status_byte_one[`SB1_PAGE_SIZE_BIT] = page_size_binary;

   // Suspended buffers refuse modification
   assign buf1_write_allow = buf1_write_req & ~buf1_suspend & command_enable;
   assign buf2_write_allow = buf2_write_req & ~buf2_suspend & command_enable;

   assign standby = (state_q == ST_STANDBY) & ~rx_selected & ~op_busy;
   assign command_enable = (state_q == ST_STANDBY);
   assign so_out = rx_so;
   assign so_oe = rx_so_oe & ~power_down_q;

   ////////////////////////////////////////////////////////////////////////
   // Serial frame front end
   spi_frame_rx u_rx (
      .clk_sys(clk_sys),
      .reset(reset),
      .clk_en(clk_en),
      .sck_pin(sck_pin),
      .cs_n_pin(cs_n_pin),
      .si_pin(si_pin),
      .status_one(status_byte_one),
      .status_two(status_byte_two),
      .stream_en(status_stream_q),
      .opcode_q(rx_opcode),
      .opcode_valid_q(rx_opcode_valid),
      .frame_end_q(rx_frame_end),
      .byte_aligned_q(rx_aligned),
      .selected_q(rx_selected),
      .so_out_q(rx_so),
      .so_oe_q(rx_so_oe)
   );

   ////////////////////////////////////////////////////////////////////////
   // Error and compare flags; error flag updates only on completed, non-aborted erase or program ops
   always @(posedge clk_sys) begin
      if (reset) begin
         erase_program_error_q <= `ERROR_RESET;
         compare_flag_q <= `COMPARE_RESET;
      end else if (clk_en) begin
         if (op_done && op_is_erase_or_program && !op_aborted) begin
            erase_program_error_q <= op_failed;
         end
         if (compare_done) begin
            compare_flag_q <= compare_mismatch;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Opcode latch and status streaming enable for the frame in progress
   always @(posedge clk_sys) begin
      if (reset) begin
         pending_q <= 1'b0;
         pending_op_q <= 8'h00;
         status_stream_q <= 1'b0;
      end else if (clk_en) begin
         if (rx_frame_end) begin
            pending_q <= 1'b0;
            status_stream_q <= 1'b0;
         end else if (rx_opcode_valid) begin
            pending_q <= 1'b1;
            pending_op_q <= rx_opcode;
            // Status read works in standby at any time, never when down
            status_stream_q <= (rx_opcode == `OP_STATUS_READ) &&
               (state_q == ST_STANDBY);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Power state next-state logic
   always @* begin
      state_d = state_q;
      timer_d = timer_q;
      case (state_q)
         ST_STANDBY: begin
            // Entry needs whole opcode, byte framing and an idle array
            if (rx_frame_end && rx_aligned && pending_q &&
                pending_op_q == `OP_DEEP_POWER_DOWN && !op_busy) begin
               state_d = ST_ENTERING;
               timer_d = 32'h0;
            end
         end
         ST_ENTERING: begin
            if (timer_q >= ENTRY_CYCLES - 1) begin
               state_d = ST_DOWN;
            end else begin
               timer_d = timer_q + 32'h1;
            end
         end
         ST_DOWN: begin
            // Any other opcode or a malformed frame keeps us down
            if (rx_frame_end && rx_aligned && pending_q &&
                pending_op_q == `OP_RESUME) begin
               state_d = ST_RESUMING;
               timer_d = 32'h0;
            end
         end
         ST_RESUMING: begin
            if (timer_q >= RESUME_CYCLES - 1) begin
               state_d = ST_STANDBY;
            end else begin
               timer_d = timer_q + 32'h1;
            end
         end
         default: begin
            state_d = ST_STANDBY;
            timer_d = 32'h0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Power state registers; reset lands in standby
   always @(posedge clk_sys) begin
      if (reset) begin
         state_q <= ST_STANDBY;
         timer_q <= 32'h0;
         power_down_q <= 1'b0;
      end else if (clk_en) begin
         state_q <= state_d;
         timer_q <= timer_d;
         // Output is silenced from entry through resume for safety
         power_down_q <= (state_d != ST_STANDBY);
      end
   end
endmodule

// ===== src/status_pd_defines.vh
// Constants for the status and deep power-down block
`ifndef STATUS_PD_DEFINES_VH
`define STATUS_PD_DEFINES_VH
`define OP_DEEP_POWER_DOWN 8'hB9
`define OP_RESUME 8'hAB
`define OP_STATUS_READ 8'hD7
`define SB2_READY_BIT 7
`define SB2_RSVD6_BIT 6
`define SB2_ERROR_BIT 5
`define SB2_RSVD4_BIT 4
`define SB2_LOCKDOWN_BIT 3
`define SB2_PS2_BIT 2
`define SB2_PS1_BIT 1
`define SB2_ERASE_SUSP_BIT 0
`define SB1_READY_BIT 7
`define SB1_COMPARE_BIT 6
`define SB1_DENSITY_LSB 2
`define SB1_PROTECT_BIT 1
`define SB1_PAGE_SIZE_BIT 0
`define ERROR_RESET 1'b0
`define COMPARE_RESET 1'b0
`define ENTRY_TIME_NS 3000
`define RESUME_TIME_NS 35000
`define CLK_PERIOD_NS 10
`define ENTRY_CYCLES ((`ENTRY_TIME_NS) / (`CLK_PERIOD_NS))
`define RESUME_CYCLES ((`RESUME_TIME_NS) / (`CLK_PERIOD_NS))
`endif

// ===== src/spi_frame_rx.v
// Serial frame receiver: synchronises the pins, shifts the opcode in and shifts status out
`timescale 1ns/1ps
`include "status_pd_defines.vh"
module spi_frame_rx (
   // Clock and control
   input wire clk_sys,
   input wire reset,
   input wire clk_en,
   // Pins
   input wire sck_pin,
   input wire cs_n_pin,
   input wire si_pin,
   // Status words to stream
   input wire [7:0] status_one,
   input wire [7:0] status_two,
   input wire stream_en,
   // Frame events
   output reg [7:0] opcode_q,
   output reg opcode_valid_q,
   output reg frame_end_q,
   output reg byte_aligned_q,
   output reg selected_q,
   output reg so_out_q,
   output reg so_oe_q
);
   reg [2:0] sync1_q;
   reg [2:0] sync2_q;
   reg sck_prev_q;
   reg cs_prev_q;
   reg [2:0] bit_cnt_q;
   reg [7:0] shift_q;
   reg got_opcode_q;
   reg [3:0] out_idx_q;
   wire sck_s;
   wire cs_n_s;
   wire si_s;
   wire sck_rise;
   wire sck_fall;
   wire cs_fall;
   wire cs_rise;
   wire [15:0] out_word;

   assign sck_s = sync2_q[0];
   assign cs_n_s = sync2_q[1];
   assign si_s = sync2_q[2];
   assign sck_rise = sck_s & ~sck_prev_q;
   assign sck_fall = ~sck_s & sck_prev_q;
   assign cs_fall = ~cs_n_s & cs_prev_q;
   assign cs_rise = cs_n_s & ~cs_prev_q;
   assign out_word = {status_one, status_two};

   ////////////////////////////////////////////////////////////////////////
   // Two-stage synchronisers; first stage feeds only the second
   always @(posedge clk_sys) begin
      if (reset) begin
         sync1_q <= 3'h3;
         sync2_q <= 3'h3;
         sck_prev_q <= 1'b1;
         cs_prev_q <= 1'b1;
      end else if (clk_en) begin
         sync1_q <= {si_pin, cs_n_pin, sck_pin};
         sync2_q <= sync1_q;
         sck_prev_q <= sck_s;
         cs_prev_q <= cs_n_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Bit counter and opcode capture; extra bytes never replace the opcode
   always @(posedge clk_sys) begin
      if (reset) begin
         bit_cnt_q <= 3'h0;
         shift_q <= 8'h00;
         got_opcode_q <= 1'b0;
         opcode_q <= 8'h00;
         opcode_valid_q <= 1'b0;
         frame_end_q <= 1'b0;
         byte_aligned_q <= 1'b0;
         selected_q <= 1'b0;
      end else if (clk_en) begin
         opcode_valid_q <= 1'b0;
         frame_end_q <= 1'b0;
         if (cs_fall) begin
            bit_cnt_q <= 3'h0;
            got_opcode_q <= 1'b0;
            selected_q <= 1'b1;
         end else if (cs_rise) begin
            frame_end_q <= 1'b1;
            byte_aligned_q <= (bit_cnt_q == 3'h0) & got_opcode_q;
            selected_q <= 1'b0;
         end else if (~cs_n_s && sck_rise) begin
            shift_q <= {shift_q[6:0], si_s};
            bit_cnt_q <= bit_cnt_q + 3'h1;
            if (bit_cnt_q == 3'h7 && !got_opcode_q) begin
               opcode_q <= {shift_q[6:0], si_s};
               opcode_valid_q <= 1'b1;
               got_opcode_q <= 1'b1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Status streaming on falling clock, MSB of byte one first, repeating
   always @(posedge clk_sys) begin
      if (reset) begin
         out_idx_q <= 4'h0;
         so_out_q <= 1'b0;
         so_oe_q <= 1'b0;
      end else if (clk_en) begin
         if (cs_n_s || !stream_en) begin
            out_idx_q <= 4'h0;
            so_oe_q <= 1'b0;
         end else if (sck_fall) begin
            so_oe_q <= 1'b1;
            so_out_q <= out_word[4'hF - out_idx_q];
            out_idx_q <= out_idx_q + 4'h1;
         end
      end
   end
endmodule

// ===== verif/status_pd_checker_properties.sv
// Port checks for the status and power-down block
`timescale 1ns/1ps
module status_pd_checker #(
   parameter [3:0] DENSITY_CODE = 4'h5
) (
   // Clock and control
   input wire clk_sys,
   input wire reset,
   input wire clk_en,
   // Array events and flags
   input wire op_busy,
   input wire op_done,
   input wire op_is_erase_or_program,
   input wire op_aborted,
   input wire op_failed,
   input wire compare_done,
   input wire compare_mismatch,
   input wire lockdown_enabled,
   input wire buf1_suspend,
   input wire buf2_suspend,
   input wire erase_suspend,
   input wire protect_enabled,
   input wire page_size_binary,
   input wire buf1_write_req,
   // Observed outputs
   input wire so_oe,
   input wire buf1_write_allow,
   input wire buf2_write_allow,
   input wire [7:0] status_byte_two,
   input wire [7:0] status_byte_one,
   input wire power_down_q,
   input wire standby
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   ////////////////////////////////////////////////////////////
   // Completion events that may touch the sticky flags
   sequence s_done_ok;
      clk_en && op_done && op_is_erase_or_program && !op_aborted;
   endsequence
   sequence s_done_abort;
      clk_en && op_done && op_aborted;
   endsequence
   a_ready_bit: assert property (
      status_byte_two[7] == !op_busy && status_byte_one[7] == !op_busy)
      else $error("ready bit disagrees with busy");
   // Bit 5 is the sticky error flag and is left to its own checks
   a_flag_bits: assert property (
      status_byte_two[6] == 1'b0 && status_byte_two[4] == 1'b0 &&
      status_byte_two[3:0] == {lockdown_enabled, buf2_suspend, buf1_suspend, erase_suspend})
      else $error("status byte two flags wrong");
   a_byte_one: assert property (
      status_byte_one[5:0] == {DENSITY_CODE, protect_enabled, page_size_binary})
      else $error("status byte one fields wrong");
   a_error_load: assert property (
      s_done_ok |=> status_byte_two[5] == $past(op_failed))
      else $error("error flag not loaded");
   a_abort_keep: assert property (s_done_abort |=> $stable(status_byte_two[5]))
      else $error("abort changed error flag");
   a_compare_load: assert property (
      clk_en && compare_done |=> status_byte_one[6] == $past(compare_mismatch))
      else $error("compare flag not loaded");
   a_busy_entry: assert property ($rose(power_down_q) |-> !$past(op_busy))
      else $error("entered power-down while busy");
   a_down_quiet: assert property (
      power_down_q |-> !so_oe && !buf1_write_allow && !buf2_write_allow)
      else $error("activity during power-down");
   a_standby_idle: assert property (standby |-> !op_busy && !power_down_q)
      else $error("standby while busy or down");
   a_write_block: assert property (buf1_write_allow |-> buf1_write_req && !buf1_suspend)
      else $error("suspended buffer modified");
   a_write_two: assert property (buf2_write_allow |-> !buf2_suspend)
      else $error("suspended buffer two modified");
   a_reset_up: assert property (disable iff (1'b0) reset |=> !power_down_q && !so_oe)
      else $error("reset did not give standby");
endmodule
bind status_pd_core status_pd_checker #(.DENSITY_CODE(DENSITY_CODE)) chk (
   .clk_sys(clk_sys), .reset(reset), .clk_en(clk_en), .op_busy(op_busy), .op_done(op_done),
   .op_is_erase_or_program(op_is_erase_or_program), .op_aborted(op_aborted),
   .op_failed(op_failed), .compare_done(compare_done), .compare_mismatch(compare_mismatch),
   .lockdown_enabled(lockdown_enabled), .buf1_suspend(buf1_suspend),
   .buf2_suspend(buf2_suspend), .erase_suspend(erase_suspend),
   .protect_enabled(protect_enabled), .page_size_binary(page_size_binary),
   .buf1_write_req(buf1_write_req), .so_oe(so_oe), .buf1_write_allow(buf1_write_allow),
   .buf2_write_allow(buf2_write_allow), .status_byte_two(status_byte_two),
   .status_byte_one(status_byte_one), .power_down_q(power_down_q), .standby(standby));

// ===== verif/spi_host_model.sv
// Behavioural serial host framing commands and collecting output bits
`timescale 1ns/1ps
module spi_host_model (
   // Clock
   input wire clk_sys,
   // Device output
   input wire so_out,
   input wire so_oe,
   // Serial pins
   output reg sck_pin = 1'b0,
   output reg cs_n_pin = 1'b1,
   output reg si_pin = 1'b0
);
   reg in_frame = 1'b0;
   ////////////////////////////////////////////////////////////
   // Data line changes every cycle outside frames so no stale bit looks valid
   always @(posedge clk_sys) begin
      if (!in_frame) begin
         si_pin <= ~si_pin;
      end
   end
   // One frame: nbits sent MSB first, then nrd bits read at clock rise
   task xfer(input [7:0] op, input integer nbits, input integer nrd, output reg [31:0] rd);
      integer i;
      begin
         rd = 32'h0;
         @(posedge clk_sys);
         in_frame <= 1'b1;
         cs_n_pin <= 1'b0;
         for (i = 0; i < nbits + nrd; i = i + 1) begin
            // Low phase 8 clocks, high phase 8: a 160 ns link clock
            repeat (4) @(posedge clk_sys);
            si_pin <= (i < 8) ? op[7 - i] : ~si_pin;
            repeat (4) @(posedge clk_sys);
            sck_pin <= 1'b1;
            if (i >= nbits) rd = {rd[30:0], so_oe ? so_out : 1'bx};
            repeat (8) @(posedge clk_sys);
            sck_pin <= 1'b0;
         end
         repeat (8) @(posedge clk_sys);
         cs_n_pin <= 1'b1;
         in_frame <= 1'b0;
         repeat (8) @(posedge clk_sys);
      end
   endtask
endmodule

// ===== verif/testbench.sv
// Self-checking bench for the status and deep power-down block
`timescale 1ns/1ps
`include "status_pd_defines.vh"
module testbench;
   localparam [3:0] DENS = 4'hA; // Arbitrary density code
   reg clk_sys = 1'b0;
   reg reset = 1'b1;
   reg op_busy = 1'b0, op_done = 1'b0, op_ep = 1'b0, op_aborted = 1'b0, op_failed = 1'b0;
   reg compare_done = 1'b0, compare_mismatch = 1'b0, wr1 = 1'b0, wr2 = 1'b0;
   reg [5:0] flg = 6'h00;
   reg clk_en = 1'b1;
   reg [31:0] rnd;
   wire sck, cs_n, si, so_out, so_oe, allow1, allow2, power_down_q, standby;
   wire [7:0] sb2, sb1;
   integer m_err = 0, m_cmp = 0, m_pd = 0, seed = 32'h664C, error_cnt = 0, num_checks = 0, i;
   reg [31:0] rd;
   reg [7:0] op;
   reg [31:0] cases = 32'h4714_5698; // Nibbles: cmp, ep, abort, fail
   ////////////////////////////////////////////////////////////
   // Clock at 100 MHz
   always #5 clk_sys = ~clk_sys;
   status_pd_core #(.ENTRY_CYCLES(5), .RESUME_CYCLES(5), .DENSITY_CODE(DENS)) uut (
      .clk_sys(clk_sys), .reset(reset), .clk_en(clk_en), .sck_pin(sck), .cs_n_pin(cs_n),
      .si_pin(si), .so_out(so_out), .so_oe(so_oe), .op_busy(op_busy), .op_done(op_done),
      .op_is_erase_or_program(op_ep), .op_aborted(op_aborted), .op_failed(op_failed),
      .compare_done(compare_done), .compare_mismatch(compare_mismatch),
      .lockdown_enabled(flg[5]), .buf2_suspend(flg[4]), .buf1_suspend(flg[3]),
      .erase_suspend(flg[2]), .protect_enabled(flg[1]), .page_size_binary(flg[0]),
      .buf1_write_req(wr1), .buf2_write_req(wr2), .buf1_write_allow(allow1),
      .buf2_write_allow(allow2), .status_byte_two(sb2), .status_byte_one(sb1),
      .power_down_q(power_down_q), .standby(standby), .command_enable());
   spi_host_model host (.clk_sys(clk_sys), .so_out(so_out), .so_oe(so_oe),
      .sck_pin(sck), .cs_n_pin(cs_n), .si_pin(si));
   ////////////////////////////////////////////////////////////
   // Both status bytes as the reference model sees them
   function [15:0] exp_st(input dummy);
      exp_st = {~op_busy, m_cmp[0], DENS, flg[1:0], ~op_busy, 1'b0, m_err[0], 1'b0, flg[5:2]};
   endfunction
   task check(input string name, input [31:0] seen, input [31:0] exp);
      begin
         num_checks = num_checks + 1;
         if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("Error %0s expected %h seen %h", name, exp, seen);
         end
      end
   endtask
   // Powered down: output never driven, so every bit reads unknown
   task read_status;
      begin
         host.xfer(`OP_STATUS_READ, 8, 32, rd);
         check("status", rd, m_pd ? 32'hXXXXXXXX : {exp_st(0), exp_st(0)});
      end
   endtask
   task event_pulse(input [3:0] v);
      begin
         @(posedge clk_sys);
         {compare_done, op_ep, op_aborted, op_failed} <= v;
         compare_mismatch <= v[0];
         op_done <= ~v[3];
         @(posedge clk_sys);
         op_done <= 1'b0;
         compare_done <= 1'b0;
         if (v[3]) m_cmp = v[0];
         else if (v[2] && !v[1]) m_err = v[0];
         repeat (2) @(posedge clk_sys);
         check("err", sb2[5], m_err);
         check("cmp", sb1[6], m_cmp);
      end
   endtask
   // Command frame, then settle time well past the entry and resume counts
   task frame(input [7:0] o, input integer n, input integer pd);
      begin
         host.xfer(o, n, 0, rd);
         repeat (30) @(posedge clk_sys);
         check("pd", power_down_q, pd);
      end
   endtask
   task end_sim;
      begin
         $display("Checks %0d mismatches %0d", num_checks, error_cnt);
         if (error_cnt == 0 && num_checks > 0) $display("== PASSED ==");
         else $display("== FAILED ==");
         $finish;
      end
   endtask
   ////////////////////////////////////////////////////////////
   // Watchdog well beyond the expected run of about 7300 cycles
   initial begin
      repeat (90000) @(posedge clk_sys);
      error_cnt = error_cnt + 1;
      end_sim;
   end
   // Main sequence
   initial begin
      repeat (10) @(posedge clk_sys);
      reset <= 1'b0;
      repeat (4) @(posedge clk_sys);
      check("pd_up", power_down_q, 0);
      check("standby", standby, 1);
      for (i = 0; i < 4; i = i + 1) begin
         rnd = $random(seed);
         flg <= rnd[5:0];
         wr1 <= 1'b1;
         wr2 <= 1'b1;
         read_status;
         check("allow1", allow1, !flg[3]);
         check("allow2", allow2, !flg[4]);
      end
      $display("Test flags done");
      for (i = 7; i >= 0; i = i - 1) event_pulse(cases[i * 4 +: 4]);
      // A passing program seen while the enable is low must not clear the flag
      @(posedge clk_sys);
      clk_en <= 1'b0;
      {op_ep, op_aborted, op_failed} <= {1'b1, 1'b0, !m_err[0]};
      op_done <= 1'b1;
      @(posedge clk_sys);
      op_done <= 1'b0;
      clk_en <= 1'b1;
      repeat (2) @(posedge clk_sys);
      check("err_frozen", sb2[5], m_err);
      $display("Test events done");
      op_busy <= 1'b1;
      read_status;
      frame(`OP_DEEP_POWER_DOWN, 8, 0);
      op_busy <= 1'b0;
      read_status;
      for (i = 0; i < 3; i = i + 1) frame(`OP_DEEP_POWER_DOWN, 5 + i * 7, 0);
      $display("Test refusals done");
      frame(`OP_DEEP_POWER_DOWN, 16, 1);
      m_pd = 1;
      read_status;
      check("allow_pd", {allow1, allow2}, flg[4:3] & 2'h0);
      for (i = 0; i < 3; i = i + 1) begin
         rnd = $random(seed);
         op = rnd[7:0];
         frame((op == `OP_RESUME) ? 8'h00 : op, 8, 1);
      end
      frame(`OP_RESUME, 4, 1);
      frame(`OP_RESUME, 8, 0);
      m_pd = 0;
      read_status;
      $display("Test power-down done");
      end_sim;
   end
endmodule
